// >>> verilog/rac_pkg.sv
// Notes on behaviour
// - alarm one 07h-0Ah, alarm two 0Bh-0Dh, writable
// - bit 7 masks field; unmasked means full match
// - alarm one mask patterns select its repeat rate
// - alarm two masks; all masked fires at :00
// - bit 6 picks day-of-week or date compare
// - compare once per second, match sets flag
// - irq while flag, enable and output select set
// - backup output enable, else pin floats on fail
// - oscillator disable bit, runs at zero, resets zero
// - rate bits pick square wave, reset 11
// - output select: wave at zero, irq at one
// - enables reset zero, gate the interrupt
// - oscillator stopped flag set on stop edge
// - stopped flag cleared only by writing zero
// - alarm flags clear on zero, one ignored
// - charger on only with select pattern 1010
// - diode field 01 none, 10 one, else off
// - resistor 250, 2k, 4k; 00 disables
// - hours bit 6 twelve-hour, bit 5 PM
// - pointer advances per byte, wraps after 10h
package rac_pkg;

	localparam logic [4:0] ADDR_SEC      = 5'h00;
	localparam logic [4:0] ADDR_MIN      = 5'h01;
	localparam logic [4:0] ADDR_HOUR     = 5'h02;
	localparam logic [4:0] ADDR_DAY      = 5'h03;
	localparam logic [4:0] ADDR_DATE     = 5'h04;
	localparam logic [4:0] ADDR_MONTH    = 5'h05;
	localparam logic [4:0] ADDR_YEAR     = 5'h06;
	localparam logic [4:0] ADDR_ALM1_SEC = 5'h07;
	localparam logic [4:0] ADDR_ALM2_DAY = 5'h0D;
	localparam logic [4:0] ADDR_CTRL     = 5'h0E;
	localparam logic [4:0] ADDR_STATUS   = 5'h0F;
	localparam logic [4:0] ADDR_TRICKLE  = 5'h10;
	localparam logic [4:0] ADDR_LAST     = 5'h10;

	// alarm array slots
	localparam int ALM1_SEC  = 0;
	localparam int ALM1_MIN  = 1;
	localparam int ALM1_HOUR = 2;
	localparam int ALM1_DAY  = 3;
	localparam int ALM2_MIN  = 4;
	localparam int ALM2_HOUR = 5;
	localparam int ALM2_DAY  = 6;

	localparam int BIT_MASK     = 7;
	localparam int BIT_DAY_SEL  = 6;
	localparam int BIT_OSC_DIS  = 7;
	localparam int BIT_BACKUP   = 5;
	localparam int BIT_RATE_HI  = 4;
	localparam int BIT_RATE_LO  = 3;
	localparam int BIT_OUT_SEL  = 2;
	localparam int BIT_A2_IE    = 1;
	localparam int BIT_A1_IE    = 0;
	localparam int BIT_OSF      = 7;
	localparam int BIT_A2F      = 1;
	localparam int BIT_A1F      = 0;

	localparam logic [7:0] CTRL_RESET    = 8'h18;
	localparam logic [7:0] CTRL_WR_MASK  = 8'hBF;
	localparam logic [7:0] TRICKLE_RESET = 8'h00;
	localparam logic [7:0] ALARM_RESET   = 8'h00;
	localparam logic [4:0] PTR_RESET     = 5'h00;
	localparam logic [3:0] CHARGE_KEY    = 4'hA;

	// square wave taps on a counter clocked at twice the crystal rate
	localparam int WAVE_BIT_1HZ   = 15;
	localparam int WAVE_BIT_4K    = 3;
	localparam int WAVE_BIT_8K    = 2;
	localparam int WAVE_BIT_32K   = 0;
	localparam logic [1:0] RATE_1HZ = 2'h0;
	localparam logic [1:0] RATE_4K  = 2'h1;
	localparam logic [1:0] RATE_8K  = 2'h2;

	// sys cycles allowed for the counters to update after a tick
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

endpackage : rac_pkg

// >>> verilog/rac_wave_div.sv
`timescale 1ns/1ns
`default_nettype none
module rac_wave_div
	import rac_pkg::*;
(
	input  wire logic       i_osc2x_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_osc_disable,
	input  wire logic [1:0] i_rate_sel,
	output logic            o_wave,
	output logic            o_sec_toggle
);

	typedef struct packed {
		logic [1:0]  dis_sync;
		logic [1:0]  rate_s1;
		logic [1:0]  rate_s2;
		logic [15:0] count;
		logic        wave;
		logic        sec_tgl;
	} rac_div_t;

	rac_div_t s_q;
	rac_div_t s_d;

	always_comb
	begin
		s_d          = s_q;
		s_d.dis_sync = {s_q.dis_sync[0], i_osc_disable};
		s_d.rate_s1  = i_rate_sel;
		s_d.rate_s2  = s_q.rate_s1;
		// a stopped oscillator freezes wave and seconds alike
		if (!s_q.dis_sync[1])
		begin
			s_d.count = s_q.count + 16'h0001;
			if (s_q.count == 16'hFFFF)
				s_d.sec_tgl = ~s_q.sec_tgl;
		end
		case (s_q.rate_s2)
			RATE_1HZ: s_d.wave = s_q.count[WAVE_BIT_1HZ];
			RATE_4K:  s_d.wave = s_q.count[WAVE_BIT_4K];
			RATE_8K:  s_d.wave = s_q.count[WAVE_BIT_8K];
			default:  s_d.wave = s_q.count[WAVE_BIT_32K];
		endcase
	end

	always_ff @(posedge i_osc2x_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_wave       = s_q.wave;
	assign o_sec_toggle = s_q.sec_tgl;

endmodule : rac_wave_div
`default_nettype wire

// >>> verilog/rac_alarm_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module rac_alarm_ctrl
	import rac_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_osc2x_clk,
	input  wire logic       i_addr_strobe,
	input  wire logic [7:0] i_addr_data,
	input  wire logic       i_wr_strobe,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_rd_strobe,
	input  wire logic [7:0] i_time_sec,
	input  wire logic [7:0] i_time_min,
	input  wire logic [7:0] i_time_hour,
	input  wire logic [7:0] i_time_day,
	input  wire logic [7:0] i_time_date,
	input  wire logic [7:0] i_time_month,
	input  wire logic [7:0] i_time_year,
	input  wire logic       i_osc_fail,
	input  wire logic       i_power_fail,
	output logic [4:0]      o_reg_ptr,
	output logic [7:0]      o_rd_data,
	output logic            o_sec_tick,
	output logic            o_osc_enable,
	output logic            o_wave_or_irq_pin_out,
	output logic            o_wave_or_irq_pin_oe,
	output logic            o_charge_enable,
	output logic            o_charge_diode,
	output logic [1:0]      o_charge_res_sel
);

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SETTLE  = 2'b01,
		ST_COMPARE = 2'b11
	} rac_tick_st_t;

	typedef struct packed {
		rac_tick_st_t    tick_st;
		logic [1:0]      settle;
		logic [4:0]      ptr;
		logic [6:0][7:0] alarm;
		logic [7:0]      ctrl;
		logic            osc_stopped_flag;
		logic            a2f;
		logic            a1f;
		logic [7:0]      trickle;
		logic [7:0]      rd_data;
		logic [1:0]      tick_sync;
		logic            tick_prev;
		logic            sec_tick;
		logic [1:0]      wave_sync;
		logic [1:0]      fail_sync;
		logic [1:0]      pf_sync;
		logic            stop_prev;
		logic            pin_out;
		logic            pin_oe;
		logic            osc_en;
		logic            chg_en;
		logic            chg_diode;
		logic [1:0]      chg_res;
	} rac_state_t;

	localparam rac_state_t STATE_RESET = '{
		tick_st:   ST_IDLE,
		settle:    2'h0,
		ptr:       PTR_RESET,
		alarm:     {7{ALARM_RESET}},
		ctrl:      CTRL_RESET,
		osc_stopped_flag:       1'b1,
		a2f:       1'b0,
		a1f:       1'b0,
		trickle:   TRICKLE_RESET,
		rd_data:   8'h00,
		tick_sync: 2'h0,
		tick_prev: 1'b0,
		sec_tick:  1'b0,
		wave_sync: 2'h0,
		fail_sync: 2'h0,
		pf_sync:   2'h0,
		stop_prev: 1'b0,
		pin_out:   1'b0,
		pin_oe:    1'b0,
		osc_en:    1'b1,
		chg_en:    1'b0,
		chg_diode: 1'b0,
		chg_res:   2'h0
	};

	rac_state_t s_q;
	rac_state_t s_d;

	logic       div_wave;
	logic       div_sec_tgl;

	// pointer step used by both read and write traffic
	function automatic logic [4:0] next_ptr(input logic [4:0] p);
		if (p >= ADDR_LAST)
			return 5'h00;
		return p + 5'h01;
	endfunction : next_ptr

	// one masked field; hours carry the 12/24 and PM bits in [6:5]
	function automatic logic field_ok(
		input logic [7:0] alm,
		input logic [7:0] tim
	);
		return alm[BIT_MASK] | (alm[6:0] == tim[6:0]);
	endfunction : field_ok

	function automatic logic daydate_ok(
		input logic [7:0] alm,
		input logic [7:0] day,
		input logic [7:0] date
	);
		logic [5:0] target;
		target = alm[BIT_DAY_SEL] ? day[5:0] : date[5:0];
		return alm[BIT_MASK] | (alm[5:0] == target);
	endfunction : daydate_ok

	function automatic logic alarm_slot(input logic [4:0] p);
		return (p >= ADDR_ALM1_SEC) && (p <= ADDR_ALM2_DAY);
	endfunction : alarm_slot

	rac_wave_div u_div (
		.i_osc2x_clk  (i_osc2x_clk),
		.i_rst_n      (i_rst_n),
		.i_osc_disable(s_q.ctrl[BIT_OSC_DIS]),
		.i_rate_sel   (s_q.ctrl[BIT_RATE_HI:BIT_RATE_LO]),
		.o_wave       (div_wave),
		.o_sec_toggle (div_sec_tgl)
	);

	always_comb
	begin
		logic       a1_hit;
		logic       a2_hit;
		logic       stopped;
		logic       irq;
		logic [4:0] slot;
		logic [4:0] acc_ptr;
		a1_hit  = 1'b0;
		a2_hit  = 1'b0;
		stopped = 1'b0;
		irq     = 1'b0;
		slot    = 5'h00;
		acc_ptr = 5'h00;

		s_d = s_q;

		// crossings from the oscillator domain and the pins
		s_d.tick_sync = {s_q.tick_sync[0], div_sec_tgl};
		s_d.tick_prev = s_q.tick_sync[1];
		s_d.wave_sync = {s_q.wave_sync[0], div_wave};
		s_d.fail_sync = {s_q.fail_sync[0], i_osc_fail};
		s_d.pf_sync   = {s_q.pf_sync[0], i_power_fail};
		s_d.sec_tick  = s_q.tick_sync[1] ^ s_q.tick_prev;

		// alarm match terms, from the current time inputs
		a1_hit = field_ok(s_q.alarm[ALM1_SEC], i_time_sec)
			& field_ok(s_q.alarm[ALM1_MIN], i_time_min)
			& field_ok(s_q.alarm[ALM1_HOUR], i_time_hour)
			& daydate_ok(s_q.alarm[ALM1_DAY], i_time_day, i_time_date);
		// alarm two has no seconds field: it fires at second zero
		a2_hit = (i_time_sec[6:0] == 7'h00)
			& field_ok(s_q.alarm[ALM2_MIN], i_time_min)
			& field_ok(s_q.alarm[ALM2_HOUR], i_time_hour)
			& daydate_ok(s_q.alarm[ALM2_DAY], i_time_day, i_time_date);

		// register port: pointer load, then one byte per strobe
		acc_ptr = s_q.ptr;
		if (i_addr_strobe)
		begin
			s_d.ptr = i_addr_data[4:0];
		end
		else if (i_wr_strobe)
		begin
			s_d.ptr = next_ptr(acc_ptr);
			if (alarm_slot(acc_ptr))
			begin
				slot = acc_ptr - ADDR_ALM1_SEC;
				s_d.alarm[slot[2:0]] = i_wr_data;
			end
			case (acc_ptr)
				ADDR_CTRL:
					s_d.ctrl = i_wr_data & CTRL_WR_MASK;
				ADDR_STATUS:
				begin
					if (!i_wr_data[BIT_OSF])
						s_d.osc_stopped_flag = 1'b0;
					if (!i_wr_data[BIT_A2F])
						s_d.a2f = 1'b0;
					if (!i_wr_data[BIT_A1F])
						s_d.a1f = 1'b0;
				end
				ADDR_TRICKLE:
					s_d.trickle = i_wr_data;
				default:
					s_d.trickle = s_q.trickle;
			endcase
		end
		else if (i_rd_strobe)
		begin
			s_d.ptr = next_ptr(acc_ptr);
			case (acc_ptr)
				ADDR_SEC:    s_d.rd_data = i_time_sec;
				ADDR_MIN:    s_d.rd_data = i_time_min;
				ADDR_HOUR:   s_d.rd_data = i_time_hour;
				ADDR_DAY:    s_d.rd_data = i_time_day;
				ADDR_DATE:   s_d.rd_data = i_time_date;
				ADDR_MONTH:  s_d.rd_data = i_time_month;
				ADDR_YEAR:   s_d.rd_data = i_time_year;
				ADDR_CTRL:   s_d.rd_data = s_q.ctrl;
				ADDR_STATUS: s_d.rd_data = {s_q.osc_stopped_flag, 5'h00, s_q.a2f,
					s_q.a1f};
				ADDR_TRICKLE: s_d.rd_data = s_q.trickle;
				default:
				begin
					if (alarm_slot(acc_ptr))
					begin
						slot = acc_ptr - ADDR_ALM1_SEC;
						s_d.rd_data = s_q.alarm[slot[2:0]];
					end
					else
						s_d.rd_data = 8'h00;
				end
			endcase
		end

		// wait for the counters to take the tick, then compare once
		case (s_q.tick_st)
			ST_IDLE:
			begin
				if (s_q.sec_tick)
				begin
					s_d.tick_st = ST_SETTLE;
					s_d.settle  = SETTLE_CYCLES;
				end
			end
			ST_SETTLE:
			begin
				s_d.settle = s_q.settle - 2'h1;
				if (s_q.settle == 2'h1)
					s_d.tick_st = ST_COMPARE;
			end
			ST_COMPARE:
			begin
				// set placed after the clear so a match wins
				if (a1_hit)
					s_d.a1f = 1'b1;
				if (a2_hit)
					s_d.a2f = 1'b1;
				s_d.tick_st = ST_IDLE;
			end
			default:
				s_d.tick_st = ST_IDLE;
		endcase

		// stop edge: disable bit or a failing crystal
		stopped = s_q.ctrl[BIT_OSC_DIS] | s_q.fail_sync[1];
		s_d.stop_prev = stopped;
		if (stopped && !s_q.stop_prev)
			s_d.osc_stopped_flag = 1'b1;
		s_d.osc_en = ~s_q.ctrl[BIT_OSC_DIS];

		// shared pin; interrupt is open drain, active low
		irq = s_q.ctrl[BIT_OUT_SEL]
			& ((s_q.a1f & s_q.ctrl[BIT_A1_IE])
			| (s_q.a2f & s_q.ctrl[BIT_A2_IE]));
		if (s_q.pf_sync[1] && !s_q.ctrl[BIT_BACKUP])
		begin
			s_d.pin_oe  = 1'b0;
			s_d.pin_out = 1'b0;
		end
		else if (s_q.ctrl[BIT_OUT_SEL])
		begin
			s_d.pin_oe  = irq;
			s_d.pin_out = 1'b0;
		end
		else
		begin
			s_d.pin_oe  = 1'b1;
			s_d.pin_out = s_q.wave_sync[1];
		end

		// charger path, every field must agree to enable it
		s_d.chg_en = (s_q.trickle[7:4] == CHARGE_KEY)
			&& (s_q.trickle[3:2] == 2'h1 || s_q.trickle[3:2] == 2'h2)
			&& (s_q.trickle[1:0] != 2'h0);
		s_d.chg_diode = s_q.trickle[3];
		s_d.chg_res   = s_d.chg_en ? s_q.trickle[1:0] : 2'h0;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= STATE_RESET;
		else
			s_q <= s_d;
	end

	assign o_reg_ptr             = s_q.ptr;
	assign o_rd_data             = s_q.rd_data;
	assign o_sec_tick            = s_q.sec_tick;
	assign o_osc_enable          = s_q.osc_en;
	assign o_wave_or_irq_pin_out = s_q.pin_out;
	assign o_wave_or_irq_pin_oe  = s_q.pin_oe;
	assign o_charge_enable       = s_q.chg_en;
	assign o_charge_diode        = s_q.chg_en & s_q.chg_diode;
	assign o_charge_res_sel      = s_q.chg_res;

endmodule : rac_alarm_ctrl
`default_nettype wire

// >>> verif/rac_alarm_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rac_chk
	import rac_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_addr_strobe,
	input  wire logic [7:0] i_addr_data,
	input  wire logic       i_wr_strobe,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_rd_strobe,
	input  wire logic [4:0] o_reg_ptr,
	input  wire logic [7:0] o_rd_data,
	input  wire logic       o_sec_tick,
	input  wire logic       o_osc_enable,
	input  wire logic       o_charge_enable,
	input  wire logic       o_charge_diode,
	input  wire logic [1:0] o_charge_res_sel
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic wr_now = i_wr_strobe && !i_addr_strobe;
	wire logic rd_now = i_rd_strobe && !i_addr_strobe && !i_wr_strobe;
	wire logic step = wr_now || rd_now;
	a_ptr_load: assert property (i_addr_strobe |=>
		o_reg_ptr == $past(i_addr_data[4:0])) else $error("ptr load");
	a_ptr_wrap: assert property (step && o_reg_ptr == ADDR_LAST |=>
		o_reg_ptr == 5'h00) else $error("ptr wrap");
	a_ptr_step: assert property (step && o_reg_ptr < ADDR_LAST |=>
		o_reg_ptr == $past(o_reg_ptr) + 5'h01) else $error("ptr step");
	a_status_zero: assert property (rd_now && o_reg_ptr == ADDR_STATUS
		|=> o_rd_data[6:2] == 5'h00) else $error("status bits");
	a_ctrl_zero: assert property (rd_now && o_reg_ptr == ADDR_CTRL
		|=> !o_rd_data[6]) else $error("control bit");
	a_key_off: assert property (wr_now && o_reg_ptr == ADDR_TRICKLE &&
		i_wr_data[7:4] != CHARGE_KEY |-> ##[1:2] !o_charge_enable)
		else $error("charger key");
	a_charge_idle: assert property (!o_charge_enable |->
		o_charge_res_sel == 2'h0 && !o_charge_diode) else $error("charge idle");
	a_osc_stop: assert property (wr_now && o_reg_ptr == ADDR_CTRL &&
		i_wr_data[7] |-> ##[1:2] !o_osc_enable) else $error("osc stop");
	a_tick_once: assert property (o_sec_tick |=> !o_sec_tick [*8])
		else $error("tick width");
endmodule : rac_chk
bind rac_alarm_ctrl rac_chk u_chk (.i_sys_clk, .i_rst_n, .i_addr_strobe,
	.i_addr_data, .i_wr_strobe, .i_wr_data, .i_rd_strobe, .o_reg_ptr,
	.o_rd_data, .o_sec_tick, .o_osc_enable, .o_charge_enable,
	.o_charge_diode, .o_charge_res_sel);
`default_nettype wire

// >>> verif/rac_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rac_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_supply_high,
	output logic            o_addr_strobe,
	output logic [7:0]      o_addr_data,
	output logic            o_wr_strobe,
	output logic [7:0]      o_wr_data,
	output logic            o_rd_strobe
);
	initial
	begin
		o_addr_strobe = 1'b0;
		o_addr_data = 8'h00;
		o_wr_strobe = 1'b0;
		o_wr_data = 8'h00;
		o_rd_strobe = 1'b0;
	end
	// released data lines flip so a stale byte is never trusted
	task automatic xfer(input logic [4:0] a, input logic wr,
		input logic [7:0] d);
		if (wr && a == 5'h10 && d[1:0] == 2'h1 && i_supply_high)
			return;
		@(posedge i_clk);
		#1;
		o_addr_strobe = 1'b1;
		o_addr_data = {3'h0, a};
		@(posedge i_clk);
		#1;
		o_addr_strobe = 1'b0;
		o_addr_data = ~o_addr_data;
		o_wr_strobe = wr;
		o_rd_strobe = !wr;
		o_wr_data = d;
		@(posedge i_clk);
		#1;
		o_wr_strobe = 1'b0;
		o_rd_strobe = 1'b0;
		o_wr_data = ~d;
	endtask : xfer
endmodule : rac_host_model
`default_nettype wire

// >>> verif/rac_alarm_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rac_alarm_ctrl_tb_top
	import rac_pkg::*;
;
	logic       sys_clk = 1'b0;
	logic       osc2x_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       osc_fail = 1'b0;
	logic       power_fail = 1'b0;
	logic       addr_stb, wr_stb, rd_stb, tick, osc_en, pin_out, pin_oe;
	logic       chg_en, chg_di, rd_seen = 1'b0;
	logic [7:0] addr_d, wr_d, rd_data, d;
	logic [4:0] ptr;
	logic [1:0] chg_res;
	logic [7:0] tm [7] = '{8'h00, 8'h12, 8'h08, 8'h03, 8'h21, 8'h01, 8'h00};
	logic [7:0] a1 [7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h12, 8'h08, 8'h43};
	logic [7:0] a2 [7] = '{8'h01, 8'h80, 8'h80, 8'h80, 8'h12, 8'h08, 8'h21};
	logic [11:0] chg [5] = '{12'hA5_9, 12'hAA_E, 12'hA7_B, 12'hAD_0, 12'hA4_0};
	logic [7:0] exp_q [$];
	int         error_cnt = 0;
	int         check_count = 0;
	int         seed = 34;

	rac_alarm_ctrl u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
		.i_osc2x_clk(osc2x_clk), .i_addr_strobe(addr_stb),
		.i_addr_data(addr_d), .i_wr_strobe(wr_stb), .i_wr_data(wr_d),
		.i_rd_strobe(rd_stb), .i_time_sec(tm[0]), .i_time_min(tm[1]),
		.i_time_hour(tm[2]), .i_time_day(tm[3]), .i_time_date(tm[4]),
		.i_time_month(tm[5]), .i_time_year(tm[6]), .i_osc_fail(osc_fail),
		.i_power_fail(power_fail), .o_reg_ptr(ptr), .o_rd_data(rd_data),
		.o_sec_tick(tick), .o_osc_enable(osc_en),
		.o_wave_or_irq_pin_out(pin_out), .o_wave_or_irq_pin_oe(pin_oe),
		.o_charge_enable(chg_en), .o_charge_diode(chg_di),
		.o_charge_res_sel(chg_res));
	rac_host_model u_host (.i_clk(sys_clk), .i_supply_high(!power_fail),
		.o_addr_strobe(addr_stb), .o_addr_data(addr_d),
		.o_wr_strobe(wr_stb), .o_wr_data(wr_d), .o_rd_strobe(rd_stb));

	initial forever #20 sys_clk = ~sys_clk;
	initial
	begin
		#3;
		forever
		begin
			#7 osc2x_clk = 1'b1;
			#8 osc2x_clk = 1'b0;
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		u_host.xfer(a, 1'b1, v);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(a, 1'b0, 8'h00);
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle
	// flags land 4 edges after the tick, the pin one later
	task automatic wait_tick();
		for (int n = 0; n < 30000 && tick !== 1'b1; n++)
		begin
			@(posedge sys_clk);
			#1;
		end
		settle(6);
	endtask : wait_tick

	// read data is valid the edge after the strobe was taken
	always @(posedge sys_clk)
	begin
		if (rd_seen)
			check(rd_data, exp_q.pop_front());
		rd_seen <= rd_stb;
	end

	initial
	begin
		#(40 * 90000);
		error_cnt++;
		stop_test();
	end

	initial
	begin
		tm[5] = $random(seed);
		tm[6] = $random(seed);
		settle(10);
		rst_n = 1'b1;
		settle(4);
		check({7'h00, pin_oe}, 8'h01);
		rd(ADDR_CTRL, 8'h18);
		rd(ADDR_STATUS, 8'h80);
		rd(ADDR_TRICKLE, 8'h00);
		wr(ADDR_STATUS, 8'hFF);
		rd(ADDR_STATUS, 8'h80);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_CTRL, 8'h7F);
		rd(ADDR_CTRL, 8'h3F);
		settle(3);
		check({pin_oe, pin_out}, 8'h00);
		for (int i = 0; i < 7; i++)
			wr(ADDR_ALM1_SEC + 5'(i), a1[i]);
		wait_tick();
		check({pin_oe, pin_out}, 8'h02);
		rd(ADDR_STATUS, 8'h03);
		wr(ADDR_STATUS, 8'h02);
		settle(3);
		check({pin_oe, pin_out}, 8'h02);
		wr(ADDR_STATUS, 8'h00);
		settle(3);
		check({pin_oe, pin_out}, 8'h00);
		for (int i = 0; i < 7; i++)
			wr(ADDR_ALM1_SEC + 5'(i), a2[i]);
		wait_tick();
		rd(ADDR_STATUS, 8'h02);
		check({pin_oe, pin_out}, 8'h02);
		wr(ADDR_CTRL, 8'h3C);
		settle(3);
		check({pin_oe, pin_out}, 8'h00);
		wr(ADDR_CTRL, 8'h18);
		power_fail = 1'b1;
		settle(8);
		check({7'h00, pin_oe}, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			d = $random(seed);
			if (d[7:4] == CHARGE_KEY)
				d[7:4] = 4'h5;
			wr(ADDR_TRICKLE, i < 5 ? chg[i][11:4] : d);
			settle(3);
			check({chg_en, chg_di, chg_res}, i < 5 ? chg[i][3:0] : 4'h0);
		end
		wr(ADDR_CTRL, 8'h98);
		settle(4);
		check({7'h00, osc_en}, 8'h00);
		rd(ADDR_STATUS, 8'h82);
		settle(3);
		stop_test();
	end
endmodule : rac_alarm_ctrl_tb_top
`default_nettype wire
